// File: src/stc_pkg.sv
package stc_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_COUNT   = 8'h04;
   localparam logic [7:0] OFS_RELOAD  = 8'h08;
   localparam logic [7:0] OFS_CAPTURE = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_MASK    = 8'h14;

   // ------------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------------
   localparam int          CTRL_W        = 10;
   localparam int          CAUSE_BIT     = 16;
   localparam int          STS_W         = 2;
   localparam int          STS_RELOAD    = 0;
   localparam int          STS_CAPTURE   = 1;
   localparam logic [15:0] COUNT_RST     = 16'h0000;
   localparam logic [15:0] RELOAD_RST    = 16'h0000;
   localparam logic [15:0] COUNT_RESTART = 16'h0001;

   // ------------------------------------------------------------------
   // modes, interrupt cause select, prescaler
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_ONESHOT = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_RESTART = 2'h2;
   localparam logic [1:0] SEL_BOTH     = 2'h0;
   localparam logic [1:0] SEL_CAPTURE  = 2'h1;
   localparam logic [1:0] SEL_RELOAD   = 2'h2;
   localparam int         PRESC_MAX    = 128;

   // control register as carried through the block
   typedef struct packed {
      logic [1:0] int_sel;   // interrupt_cause_select
      logic       out_en;    // timer output alternate function
      logic       pol;       // output_polarity_bit
      logic [2:0] presc;     // divide by 2**presc
      logic [1:0] mode;
      logic       enable;
   } stc_ctrl_t;

endpackage : stc_pkg

// File: src/stc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// timer input synchroniser and edge detector
// ---------------------------------------------------------------------
module stc_edge_sync
   import stc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // pin and edge choice
   input  wire logic pin,
   input  wire logic fall_sel,
   // event
   output var  logic edge_pulse
);

   logic meta;
   logic sync;
   logic last;
   logic [1:0] arm;

   // edges wait until the chain holds real pin samples: a pin idle high gives no edge at reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm <= 2'h0;
      end else if (arm != 2'h3) begin
         arm <= arm + 2'h1;
      end
   end

   // two flops before any logic looks at the pin
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   // one pulse per accepted edge, polarity picks rise or fall
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= (arm == 2'h3) & (fall_sel ? (last & ~sync) : (~last & sync));
      end
   end

endmodule : stc_edge_sync

`default_nettype wire

// File: src/stc_timer.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - sixteen-bit up-counter, one step per tick
// - FFFFH wraps to 0000H, keeps counting
// - prescaler divides by 1 up to 128
// - one-shot counts up to reload value
// - one-shot reload: interrupt, count becomes 0001H
// - one-shot reload clears the enable bit
// - output pin inverts one cycle at one-shot reload
// - capture edge: interrupt, cause flag set
// - capture-mode reload: interrupt, flag cleared
// - interrupt cause select: both, capture, reload
// - capture copies count into capture register
// - polarity bit picks capture edge
// - restart mode records count on edge
// - one count per prescale system clocks
module stc_timer
   import stc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // timer pins
   input  wire logic        tmr_in,
   output var  logic        tmr_out,
   // interrupt
   output var  logic        irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   stc_ctrl_t          ctrl;
   logic [15:0]        count;
   logic [15:0]        reload;
   logic [15:0]        capture;
   logic               cause_flag;
   logic [STS_W-1:0]   status;
   logic [STS_W-1:0]   mask;
   logic [6:0]         presc_cnt;
   logic [6:0]         presc_lim;
   logic               tick;
   logic               hit;
   logic               is_oneshot;
   logic               is_cap;
   logic               in_edge;
   logic               cap_take;
   logic [STS_W-1:0]   sts_set;
   logic [STS_W-1:0]   next_status;
   logic               setup;
   logic               wr;
   logic               mapped;
   logic [31:0]        rdata;
   logic               run_pol;
   logic               out_lvl;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pready & pwrite;

   // read mux and address check
   always_comb begin
      rdata  = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         OFS_CTRL: begin
            rdata[CTRL_W-1:0] = ctrl;
            rdata[CAUSE_BIT]  = cause_flag;
         end
         OFS_COUNT:   rdata[15:0]      = count;
         OFS_RELOAD:  rdata[15:0]      = reload;
         OFS_CAPTURE: rdata[15:0]      = capture;
         OFS_STATUS:  rdata[STS_W-1:0] = status;
         OFS_MASK:    rdata[STS_W-1:0] = mask;
         default:     mapped           = 1'b0;
      endcase
   end

   // no wait state: answer prepared in setup, shown in the first access cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         prdata  <= (setup & ~pwrite) ? rdata : 32'h0000_0000;
         pslverr <= setup & ~mapped;
      end
   end

   // ------------------------------------------------------------------
   // prescaler and events
   // ------------------------------------------------------------------
   assign presc_lim  = 7'((8'h01 << ctrl.presc) - 8'h01);
   assign tick       = ctrl.enable && (presc_cnt == presc_lim);
   assign hit        = tick && (count == reload);
   assign is_oneshot = (ctrl.mode == MODE_ONESHOT);
   assign is_cap     = ctrl.enable && !is_oneshot;
   assign cap_take   = is_cap && in_edge;

   // divider: a tick every 2**presc system clocks
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_cnt <= 7'h00;
      end else if (!ctrl.enable || tick) begin
         presc_cnt <= 7'h00;
      end else begin
         presc_cnt <= presc_cnt + 7'h01;
      end
   end

   // input pin synchroniser
   stc_edge_sync u_sync (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .pin        (tmr_in),
      .fall_sel   (ctrl.pol),
      .edge_pulse (in_edge)
   );

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // control; one-shot reload drops the enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
      end else if (wr && paddr == OFS_CTRL) begin
         ctrl <= stc_ctrl_t'(pwdata[CTRL_W-1:0]);
      end else if (hit && is_oneshot) begin
         ctrl.enable <= 1'b0;
      end
   end

   // counter
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= COUNT_RST;
      end else if (wr && paddr == OFS_COUNT) begin
         count <= pwdata[15:0];
      end else if (cap_take && ctrl.mode == MODE_RESTART) begin
         count <= COUNT_RESTART;
      end else if (hit) begin
         count <= COUNT_RESTART;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end

   // reload value
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reload <= RELOAD_RST;
      end else if (wr && paddr == OFS_RELOAD) begin
         reload <= pwdata[15:0];
      end
   end

   // capture value; a capture beats a software write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture <= 16'h0000;
      end else if (cap_take) begin
         capture <= count;
      end else if (wr && paddr == OFS_CAPTURE) begin
         capture <= pwdata[15:0];
      end
   end

   // capture cause flag
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_flag <= 1'b0;
      end else if (cap_take) begin
         cause_flag <= 1'b1;
      end else if (hit && is_cap) begin
         cause_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------------
   // cause select filters which events may raise the line
   always_comb begin
      sts_set              = '0;
      sts_set[STS_RELOAD]  = hit && (ctrl.int_sel != SEL_CAPTURE);
      sts_set[STS_CAPTURE] = cap_take && (ctrl.int_sel != SEL_RELOAD);
      next_status          = status;
      if (wr && paddr == OFS_STATUS) begin
         next_status = status & ~pwdata[STS_W-1:0];
      end
      next_status = next_status | sts_set; // set wins over clear
   end

   // sticky status, mask and interrupt line
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         if (wr && paddr == OFS_MASK) begin
            mask <= pwdata[STS_W-1:0];
         end
         irq <= |(status & mask);
      end
   end

   // ------------------------------------------------------------------
   // timer output pin
   // ------------------------------------------------------------------
   // level latched while stopped, so a polarity write while running shows after time-out
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_pol <= 1'b0;
      end else if (!ctrl.enable) begin
         run_pol <= ctrl.pol;
      end
   end

   assign out_lvl = ctrl.enable ? run_pol : ctrl.pol;

   // held level, inverted for one cycle at a one-shot reload
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_out <= 1'b0;
      end else begin
         tmr_out <= ctrl.out_en & (out_lvl ^ (hit && is_oneshot));
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   logic wr_cnt;
   logic wr_ctl;
   assign wr_cnt = wr && paddr == OFS_COUNT;
   assign wr_ctl = wr && paddr == OFS_CTRL;

   a_count_wrap: assert property (
      (tick && count == 16'hffff && !hit && !cap_take && !wr_cnt) |=> count == 16'h0000)
      else $error("count did not wrap to zero");

   a_count_step: assert property (
      (tick && !hit && !cap_take && !wr_cnt) |=> count == $past(count) + 16'h0001)
      else $error("count did not advance by one");

   a_oneshot_end: assert property (
      (hit && is_oneshot && !wr_ctl && !wr_cnt)
         |=> (count == 16'h0001 && !ctrl.enable) ##1 !tick)
      else $error("one-shot did not reload and stop");

   a_out_pulse: assert property (
      (hit && is_oneshot && ctrl.out_en && !wr_ctl)
         |=> (tmr_out != $past(run_pol)) ##1 (tmr_out == ctrl.pol))
      else $error("output pulse not one cycle");

   a_capture_copy: assert property (
      cap_take |=> (capture == $past(count) && cause_flag))
      else $error("capture value or cause flag wrong");

   a_cause_clear: assert property (
      (hit && is_cap && !cap_take) |=> !cause_flag)
      else $error("cause flag not cleared on reload");

   a_restart_cnt: assert property (
      (cap_take && ctrl.mode == MODE_RESTART && !wr_cnt) |=> count == 16'h0001)
      else $error("restart did not reset count");

   a_presc_gap: assert property (
      (tick && ctrl.presc == 3'h1 && !wr_ctl) |=> !tick ##1 (tick || !ctrl.enable))
      else $error("divide by two tick spacing wrong");

   a_sel_filter: assert property (
      (hit && ctrl.int_sel == SEL_CAPTURE && !status[STS_RELOAD]) |=> !status[STS_RELOAD])
      else $error("reload raised status while masked by select");

   a_irq_level: assert property (
      (sts_set[STS_CAPTURE] && mask[STS_CAPTURE]) |=> ##1 irq)
      else $error("interrupt line not raised");

   a_one_event: assert property (
      cap_take |=> !cap_take)
      else $error("two capture events for one edge");

   c_oneshot: cover property (hit && is_oneshot);
   c_capture: cover property (cap_take && ctrl.mode == MODE_CAPTURE);
   c_restart: cover property (cap_take && ctrl.mode == MODE_RESTART);
   c_wrap:    cover property (tick && count == 16'hffff);

endmodule : stc_timer

`default_nettype wire

// File: tb/stc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------
// timer input source, follows a wanted level after a delay
// ----------------------------------------------------------
module stc_pin_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // wanted level and delay in clocks
   input  wire logic       lvl,
   input  wire logic [3:0] lag,
   // pin
   output var  logic       pin
);
   logic [3:0] wait_cnt;

   // one clean transition per change of the wanted level
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin      <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (lvl == pin) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= lag) begin
         pin      <= lvl;
         wait_cnt <= 4'h0;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : stc_pin_model

`default_nettype wire

// File: tb/sixteen_bit_timer_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_timer_capture_bench import stc_pkg::*; ();
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic        lvl       = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tmr_in;
   logic        tmr_out;
   logic        irq;
   logic [31:0] rd;
   logic [31:0] c1;
   logic        er;
   int          err_count = 0;
   int          n_tests   = 0;
   int          cyc       = 0;
   int          tp, t0, n;
   typedef struct { logic [2:0] p; logic [15:0] st; logic [15:0] rl; int e; } stc_row_t;
   stc_row_t rows [5] = '{'{3'h0, 16'h0001, 16'h0003, 3}, '{3'h2, 16'h0001, 16'h0003, 12},
                          '{3'h7, 16'h0001, 16'h0001, 128}, '{3'h0, 16'hfffe, 16'h0001, 4},
                          '{3'h1, 16'h0001, 16'h0002, 4}};
   logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_CAPTURE, OFS_STATUS, OFS_MASK};

   stc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
                  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                  .pready(pready), .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out),
                  .irq(irq));
   stc_pin_model pm (.sys_clk(sys_clk), .rst_n(rst_n), .lvl(lvl), .lag(4'h2), .pin(tmr_in));

   // clock and cycle ceiling
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer, read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] p,
                                       input logic pl, input logic oe, input logic [1:0] s,
                                       input logic en);
      stc_ctrl_t c;
      c = '{int_sel: s, out_en: oe, pol: pl, presc: p, mode: m, enable: en};
      return {22'h0, c};
   endfunction : ctl

   // move the pin and let the synchroniser settle
   task automatic pin(input logic v);
      @(posedge sys_clk);
      lvl <= v;
      tp  = cyc;
      repeat (12) @(posedge sys_clk);
   endtask : pin

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      // one-shot rows: prescale, start, reload, clocks to time-out
      foreach (rows[i]) begin
         apb(1, OFS_CTRL, ctl(MODE_ONESHOT, rows[i].p, 1'b0, 1'b1, SEL_BOTH, 1'b0));
         apb(1, OFS_COUNT, {16'h0, rows[i].st});
         apb(1, OFS_RELOAD, {16'h0, rows[i].rl});
         apb(1, OFS_MASK, 32'h1);
         apb(1, OFS_CTRL, ctl(MODE_ONESHOT, rows[i].p, 1'b0, 1'b1, SEL_BOTH, 1'b1));
         n = 0;
         while (tmr_out !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         check(n, rows[i].e);
         @(posedge sys_clk);
         #1;
         check(tmr_out, 1'b0);
         check(irq, 1'b1);
         apb(0, OFS_COUNT, 0);
         check(rd, 32'h1);
         apb(0, OFS_CTRL, 0);
         check(rd, ctl(MODE_ONESHOT, rows[i].p, 1'b0, 1'b1, SEL_BOTH, 1'b0));
         apb(1, OFS_STATUS, 32'h1);
         apb(0, OFS_STATUS, 0);
         check({rd, irq}, 33'h0);
         $display("one-shot row %0d done", i);
      end
      // lasting output change: preset the level, flip polarity once running
      apb(1, OFS_CTRL, ctl(MODE_ONESHOT, 3'h0, 1'b0, 1'b1, SEL_BOTH, 1'b0));
      apb(1, OFS_COUNT, 32'h1);
      apb(1, OFS_RELOAD, 32'h40);
      apb(1, OFS_CTRL, ctl(MODE_ONESHOT, 3'h0, 1'b0, 1'b1, SEL_BOTH, 1'b1));
      apb(1, OFS_CTRL, ctl(MODE_ONESHOT, 3'h0, 1'b1, 1'b1, SEL_BOTH, 1'b1));
      @(posedge sys_clk);
      #1;
      check(tmr_out, 1'b0);
      n = 0;
      while (tmr_out !== 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      repeat (3) @(posedge sys_clk);
      #1;
      check(tmr_out, 1'b1);
      apb(1, OFS_STATUS, 32'h1);
      $display("lasting level done");
      // capture mode, rising then falling edges, both causes
      apb(1, OFS_CTRL, ctl(MODE_CAPTURE, 3'h0, 1'b0, 1'b0, SEL_BOTH, 1'b0));
      apb(1, OFS_COUNT, 32'h1);
      apb(1, OFS_RELOAD, 32'hffff);
      apb(1, OFS_CAPTURE, 32'h0);
      apb(1, OFS_MASK, 32'h3);
      apb(1, OFS_CTRL, ctl(MODE_CAPTURE, 3'h0, 1'b0, 1'b0, SEL_BOTH, 1'b1));
      pin(1'b1);
      t0 = tp;
      apb(0, OFS_CAPTURE, 0);
      c1 = rd;
      apb(0, OFS_CTRL, 0);
      check({rd[CAUSE_BIT], irq}, 2'b11);
      apb(0, OFS_STATUS, 0);
      check(rd, 32'h2);
      pin(1'b0);
      apb(0, OFS_CAPTURE, 0);
      check(rd, c1);
      pin(1'b1);
      apb(0, OFS_CAPTURE, 0);
      check(rd, c1 + tp - t0);
      apb(1, OFS_CTRL, ctl(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, SEL_BOTH, 1'b1));
      pin(1'b0);
      apb(0, OFS_CAPTURE, 0);
      check(rd, c1 + tp - t0);
      // reload in capture mode clears the cause flag
      apb(1, OFS_COUNT, 32'h1);
      apb(1, OFS_RELOAD, 32'h10);
      repeat (30) @(posedge sys_clk);
      apb(0, OFS_CTRL, 0);
      check(rd[CAUSE_BIT], 1'b0);
      apb(1, OFS_MASK, 32'h0);
      apb(1, OFS_STATUS, 32'h3);
      repeat (40) @(posedge sys_clk);
      apb(0, OFS_STATUS, 0);
      check({rd, irq}, 33'h2);
      $display("capture done");
      // cause select: capture only, then reload only
      apb(1, OFS_CTRL, ctl(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, SEL_CAPTURE, 1'b1));
      apb(1, OFS_STATUS, 32'h3);
      repeat (40) @(posedge sys_clk);
      pin(1'b1);
      apb(0, OFS_STATUS, 0);
      check(rd, 32'h0);
      pin(1'b0);
      apb(0, OFS_STATUS, 0);
      check(rd, 32'h2);
      apb(1, OFS_CTRL, ctl(MODE_CAPTURE, 3'h0, 1'b1, 1'b0, SEL_RELOAD, 1'b1));
      apb(1, OFS_STATUS, 32'h3);
      apb(1, OFS_MASK, 32'h3);
      pin(1'b1);
      pin(1'b0);
      apb(0, OFS_STATUS, 0);
      check({rd, irq}, 33'h3);
      $display("cause select done");
      // capture restart: second capture equals the gap
      apb(1, OFS_RELOAD, 32'hffff);
      apb(1, OFS_CTRL, ctl(MODE_RESTART, 3'h0, 1'b0, 1'b0, SEL_BOTH, 1'b1));
      pin(1'b1);
      t0 = tp;
      pin(1'b0);
      pin(1'b1);
      apb(0, OFS_CAPTURE, 0);
      check(rd, tp - t0);
      $display("restart done");
      // reset in mid-run, then reset values and unmapped access
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check({irq, tmr_out, pready}, 3'h0);
      rst_n <= 1'b1;
      foreach (ofs[i]) begin
         apb(0, ofs[i], 0);
         check({er, rd}, 33'h0);
      end
      apb(1, OFS_CAPTURE, 32'hffff0055);
      apb(0, OFS_CAPTURE, 0);
      check(rd, 32'h55);
      apb(1, 8'h18, 32'h1);
      apb(0, 8'h18, 0);
      check({er, rd}, 33'h100000000);
      $display("reset and map done");
      end_of_test();
   end
endmodule : sixteen_bit_timer_capture_bench

`default_nettype wire
